//--- rtl/ufc_pkg.sv
// Package for the serial-port FIFO threshold control block.
// Assumes a single 50 MHz system clock and an 8-bit special-function register port.
`default_nettype none

package ufc_pkg;

  // ****************************************
  // Field layout of the FIFO control register
  // ****************************************
  localparam int unsigned FCN_TX_IRQ_EN_BIT = 7;
  localparam int unsigned FCN_TX_FLUSH_BIT  = 6;
  localparam int unsigned FCN_TX_TH_HI      = 5;
  localparam int unsigned FCN_TX_TH_LO      = 4;
  localparam int unsigned FCN_RX_IRQ_EN_BIT = 3;
  localparam int unsigned FCN_RX_FLUSH_BIT  = 2;
  localparam int unsigned FCN_RX_TH_HI      = 1;
  localparam int unsigned FCN_RX_TH_LO      = 0;
  localparam logic [7:0]  FCN_RESET         = 8'h00;
  localparam logic [1:0]  TH_RESET          = 2'h0;

  // ****************************************
  // FIFO geometry defaults
  // ****************************************
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // Flush sequencer states, one-hot
  typedef enum logic [1:0] {
    UFC_FL_IDLE  = 2'h1,
    UFC_FL_CLEAR = 2'h2
  } ufc_flush_state_type;

endpackage : ufc_pkg

`default_nettype wire

//--- rtl/ufc_fifo.sv
// Synchronous byte FIFO with valid/ready on both sides and a flush input.
// Assumes one clock; flush empties the store in one cycle.
`default_nettype none

module ufc_fifo
  import ufc_pkg::*;
#(
  parameter int unsigned WIDTH = FIFO_WIDTH,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // Control
  input  wire logic                     flush_i,
  // Fill side
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [WIDTH-1:0]         in_data_i,
  // Drain side
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic      [WIDTH-1:0]         out_data_o,
  // Fill level
  output logic      [$clog2(DEPTH+1)-1:0] count_o
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } ufc_fifo_state_type;

  ufc_fifo_state_type st_reg;
  ufc_fifo_state_type st_next;
  logic [WIDTH-1:0]   mem [DEPTH];
  logic               push;
  logic               pop;

  // ****************************************
  // Handshake
  // ****************************************
  // Ready drops when full so the source really stalls
  assign in_ready_o  = (st_reg.count != CW'(DEPTH)) && !flush_i;
  assign out_valid_o = (st_reg.count != '0) && !flush_i;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign count_o     = st_reg.count;
  assign out_data_o  = mem[st_reg.rd_ptr];

  // Next pointers and level; flush overrides everything
  always_comb begin
    st_next = st_reg;
    if (flush_i) begin
      st_next = '0;
    end else begin
      if (push) begin
        st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : st_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
        st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : st_reg.rd_ptr + 1'b1;
      end
      st_next.count = st_reg.count + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Storage has no reset; only valid entries are ever read out
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[st_reg.wr_ptr] <= in_data_i;
    end
  end

endmodule : ufc_fifo

`default_nettype wire

//--- rtl/ufc_top.sv
// Serial-port FIFO control: two byte FIFOs, fill-level thresholds, request
// flags, interrupt gating and self-clearing flush bits.
// Assumes a core that writes and reads the control register on a simple
// strobed special-function register port in the system clock domain.
`default_nettype none

module ufc_top
  import ufc_pkg::*;
#(
  parameter int unsigned WIDTH = FIFO_WIDTH,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // Special-function register port
  input  wire logic             reg_wr_i,
  input  wire logic [7:0]       reg_wdata_i,
  output logic      [7:0]       reg_rdata_o,
  // Transmit path: core fills, shifter drains
  input  wire logic             tx_in_valid_i,
  output logic                  tx_in_ready_o,
  input  wire logic [WIDTH-1:0] tx_in_data_i,
  output logic                  tx_out_valid_o,
  input  wire logic             tx_out_ready_i,
  output logic      [WIDTH-1:0] tx_out_data_o,
  // Receive path: shifter fills, core drains
  input  wire logic             rx_in_valid_i,
  output logic                  rx_in_ready_o,
  input  wire logic [WIDTH-1:0] rx_in_data_i,
  output logic                  rx_out_valid_o,
  input  wire logic             rx_out_ready_i,
  output logic      [WIDTH-1:0] rx_out_data_o,
  // Status and interrupt
  output logic                  tx_request_flag_o,
  output logic                  rx_request_flag_o,
  output logic                  irq_o
);

  localparam int unsigned CW = $clog2(DEPTH+1);

  // ****************************************
  // Control register layout
  // ****************************************
  // Bit 7    : transmit request interrupt enable
  // Bit 6    : transmit FIFO flush, cleared by hardware
  // Bits 5:4 : transmit fill threshold
  // Bit 3    : receive request interrupt enable
  // Bit 2    : receive FIFO flush, cleared by hardware
  // Bits 1:0 : receive fill threshold
  // Every field resets to zero
  // All fields load together on a write strobe, except that flush bits can only be set by it; there is no partial write
  // Readback is the register itself, so it needs no read strobe

  // ****************************************
  // Flush timing, write strobe sampled at edge W
  // ****************************************
  // Edge W     : flush bit set, sequencer still idle
  // Edge W+1   : sequencer sees the pending bit and enters the clear state
  // W+1 to W+2 : flush drives the FIFO, both its handshakes are held low
  // Edge W+2   : FIFO empty, pointers home, flush bit dropped
  // Edge W+2   : readback shows the flush bit low again, at the same edge
  // Writing zero to a pending flush bit does not cancel it
  // Writing one in the clear cycle keeps the bit for a second pass
  // Both bits pending together are served in the same clear cycle
  // A push and a flush in one cycle: the flush wins, the byte is refused
  // Flush lasts one cycle whatever the depth; storage keeps stale bytes
  // Stale bytes stay on the data output with valid low: only the pointers and the level are cleared

  // ****************************************
  // Flag and interrupt timing
  // ****************************************
  // Request flags are registered from the FIFO levels of the previous cycle
  // The interrupt is registered from the flags, one cycle further behind
  // Registering both costs latency but keeps the interrupt free of glitches
  // A threshold of zero needs no special case: the compare gives empty or nonempty
  // Thresholds reach three at most, well inside the default FIFO depth
  // With DEPTH below four a high threshold keeps the transmit flag set
  // Transmit flag resets high: an empty FIFO meets any threshold
  // Enable bits gate only the interrupt, never the flags themselves
  // The flags are not sticky: they follow the level and need no clearing
  // Flags and register fields share one packed state word

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                tx_request_irq_enable;
    logic                tx_fifo_flush;
    logic [1:0]          tx_fill_threshold;
    logic                rx_request_irq_enable;
    logic                rx_fifo_flush;
    logic [1:0]          rx_fill_threshold;
    ufc_flush_state_type fl_state;
    logic                tx_req;
    logic                rx_req;
    logic                irq;
  } ufc_state_type;

  ufc_state_type st_reg;
  ufc_state_type st_next;
  logic [CW-1:0] tx_count;
  logic [CW-1:0] rx_count;
  logic          flush_tx;
  logic          flush_rx;

  // Flush is applied to the FIFO in the clear state only, one cycle long
  assign flush_tx = (st_reg.fl_state == UFC_FL_CLEAR) && st_reg.tx_fifo_flush;
  assign flush_rx = (st_reg.fl_state == UFC_FL_CLEAR) && st_reg.rx_fifo_flush;

  // ****************************************
  // FIFOs
  // ****************************************
  ufc_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (flush_tx),
    .in_valid_i  (tx_in_valid_i),
    .in_ready_o  (tx_in_ready_o),
    .in_data_i   (tx_in_data_i),
    .out_valid_o (tx_out_valid_o),
    .out_ready_i (tx_out_ready_i),
    .out_data_o  (tx_out_data_o),
    .count_o     (tx_count)
  );

  ufc_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (flush_rx),
    .in_valid_i  (rx_in_valid_i),
    .in_ready_o  (rx_in_ready_o),
    .in_data_i   (rx_in_data_i),
    .out_valid_o (rx_out_valid_o),
    .out_ready_i (rx_out_ready_i),
    .out_data_o  (rx_out_data_o),
    .count_o     (rx_count)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  // Flags are registered from the current levels, so they lag the FIFO by one cycle
  always_comb begin
    st_next = st_reg;
    // Register write; a flush bit written as one stays set until the sequencer clears it
    if (reg_wr_i) begin
      st_next.tx_request_irq_enable = reg_wdata_i[FCN_TX_IRQ_EN_BIT];
      st_next.tx_fifo_flush         = reg_wdata_i[FCN_TX_FLUSH_BIT] | st_reg.tx_fifo_flush;
      st_next.tx_fill_threshold     = reg_wdata_i[FCN_TX_TH_HI:FCN_TX_TH_LO];
      st_next.rx_request_irq_enable = reg_wdata_i[FCN_RX_IRQ_EN_BIT];
      st_next.rx_fifo_flush         = reg_wdata_i[FCN_RX_FLUSH_BIT] | st_reg.rx_fifo_flush;
      st_next.rx_fill_threshold     = reg_wdata_i[FCN_RX_TH_HI:FCN_RX_TH_LO];
    end
    // Flush sequencer: idle sees a pending bit, clear empties the FIFO and drops the bit
    case (st_reg.fl_state)
      UFC_FL_IDLE: begin
        if (st_reg.tx_fifo_flush || st_reg.rx_fifo_flush) begin
          st_next.fl_state = UFC_FL_CLEAR;
        end
      end
      UFC_FL_CLEAR: begin
        // A fresh write of one in this cycle keeps its bit for another pass
        if (!(reg_wr_i && reg_wdata_i[FCN_TX_FLUSH_BIT])) begin
          st_next.tx_fifo_flush = 1'b0;
        end
        if (!(reg_wr_i && reg_wdata_i[FCN_RX_FLUSH_BIT])) begin
          st_next.rx_fifo_flush = 1'b0;
        end
        st_next.fl_state = UFC_FL_IDLE;
      end
      default: begin
        st_next.fl_state = UFC_FL_IDLE;
      end
    endcase
    // Threshold compares; zero threshold falls out as empty / nonempty
    st_next.tx_req = (tx_count <= CW'(st_reg.tx_fill_threshold));
    st_next.rx_req = (rx_count >  CW'(st_reg.rx_fill_threshold));
    // Interrupt follows the flags, each gated by its own enable
    st_next.irq = (st_reg.tx_req && st_reg.tx_request_irq_enable)
                | (st_reg.rx_req && st_reg.rx_request_irq_enable);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg                       <= '0;
      st_reg.fl_state              <= UFC_FL_IDLE;
      st_reg.tx_fill_threshold     <= TH_RESET;
      st_reg.rx_fill_threshold     <= TH_RESET;
      st_reg.tx_req                <= 1'b1; // Empty FIFO at reset is at or below zero
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_o = {st_reg.tx_request_irq_enable, st_reg.tx_fifo_flush, st_reg.tx_fill_threshold,
                        st_reg.rx_request_irq_enable, st_reg.rx_fifo_flush, st_reg.rx_fill_threshold};
  assign tx_request_flag_o = st_reg.tx_req;
  assign rx_request_flag_o = st_reg.rx_req;
  assign irq_o             = st_reg.irq;

endmodule : ufc_top

`default_nettype wire

//--- test/ufc_properties.sv
// Port checker for the FIFO threshold control block.
// Assumes a bind onto ufc_top; sees only its ports.
`default_nettype none
module ufc_properties (
  // Clock, reset, register port
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // FIFO and status outputs
  input wire logic       tx_in_ready_o,
  input wire logic       tx_out_valid_o,
  input wire logic       rx_out_valid_o,
  input wire logic       tx_request_flag_o,
  input wire logic       rx_request_flag_o,
  input wire logic       irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Flags lag the level by one cycle; flush cycles are left out
  property p_tx_empty; !$past(tx_out_valid_o) && !$past(reg_rdata_o[6]) |-> tx_request_flag_o; endproperty
  property p_tx_zero; $past(reg_rdata_o[5:4]) == 2'h0 && !$past(reg_rdata_o[6])
    |-> tx_request_flag_o == !$past(tx_out_valid_o); endproperty
  property p_rx_zero; $past(reg_rdata_o[1:0]) == 2'h0 && !$past(reg_rdata_o[2])
    |-> rx_request_flag_o == $past(rx_out_valid_o); endproperty
  property p_irq; irq_o == $past(tx_request_flag_o & reg_rdata_o[7] | rx_request_flag_o & reg_rdata_o[3]); endproperty
  property p_irq_off; !$past(reg_rdata_o[7]) && !$past(reg_rdata_o[3]) |-> !irq_o; endproperty
  property p_fields; reg_wr_i |=> {reg_rdata_o[7], reg_rdata_o[5:3], reg_rdata_o[1:0]}
    == $past({reg_wdata_i[7], reg_wdata_i[5:3], reg_wdata_i[1:0]}); endproperty
  // Pending, clearing, then the bit falls
  property p_tx_flush; $rose(reg_rdata_o[6]) |-> reg_rdata_o[6] ##1 reg_rdata_o[6] ##1 !reg_rdata_o[6]; endproperty
  property p_tx_empty_after; $rose(reg_rdata_o[6]) |-> ##1 !tx_in_ready_o ##1 !tx_out_valid_o; endproperty
  property p_rx_flush; $rose(reg_rdata_o[2]) |-> ##2 !rx_out_valid_o && !reg_rdata_o[2]; endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx flag low on empty fifo");
  a_tx_zero: assert property (p_tx_zero) else $error("tx flag wrong at threshold zero");
  a_rx_zero: assert property (p_rx_zero) else $error("rx flag wrong at threshold zero");
  a_irq: assert property (p_irq) else $error("irq does not follow gated flags");
  a_irq_off: assert property (p_irq_off) else $error("irq with both enables off");
  a_fields: assert property (p_fields) else $error("control fields not written");
  a_tx_flush: assert property (p_tx_flush) else $error("tx flush bit not cleared");
  a_tx_empty_after: assert property (p_tx_empty_after) else $error("tx fifo not emptied");
  a_rx_flush: assert property (p_rx_flush) else $error("rx flush incomplete");
  c_flush: cover property ($rose(reg_rdata_o[6]));
  c_irq: cover property ($rose(irq_o));
  c_rx_top: cover property (rx_request_flag_o && reg_rdata_o[1:0] == 2'h3);
endmodule : ufc_properties
bind ufc_top ufc_properties chk_u (.clk_i, .rst_b_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .tx_in_ready_o,
  .tx_out_valid_o, .rx_out_valid_o, .tx_request_flag_o, .rx_request_flag_o, .irq_o);
`default_nettype wire

//--- test/ufc_link_model.sv
// Far-side model: pushes bytes into one FIFO and drains the other.
// Assumes the block's clock; changes outputs 1 ns after rising edges.
`default_nettype none
module ufc_link_model (
  // Clock and drain control
  input  wire logic       clk_i,
  input  wire logic       drain_i,
  output logic            pop_o,
  // Fill side
  output logic            push_valid_o,
  input  wire logic       push_ready_i,
  output logic      [7:0] push_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Drains only on command so the bench can fill to full
  assign pop_o = drain_i;
  initial begin
    push_valid_o = 1'b0;
    push_data_o  = 8'hA5;
  end
  // Holds each byte until taken; ok drops if the far end stalls too long
  task automatic push(input int n, output bit ok);
    int w;
    bit rdy;
    ok = 1'b1;
    for (int k = 0; k < n; k++) begin
      push_valid_o = 1'b1;
      push_data_o  = 8'(k);
      w = 0;
      do begin
        @(posedge clk_i);
        rdy = push_ready_i;
        w++;
      end while (!rdy && w < 20);
      ok &= rdy;
      #1;
    end
    push_valid_o = 1'b0;
    // Released data shows the inverse, never the last byte
    push_data_o  = ~push_data_o;
  endtask : push
endmodule : ufc_link_model
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench: writes, fills, flushes and drains of ufc_top.
// Assumes two link models on the byte streams and a 50 MHz clock.
`default_nettype none
module tb_top
  import ufc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, drain_tx = 1'b0, drain_rx = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, tx_d, tx_q, rx_d, rx_q;
  logic       tx_v, tx_r, tx_ov, tx_pop, rx_v, rx_r, rx_ov, rx_pop, tx_flag, rx_flag, irq;
  int         n_mismatch = 0, comparisons = 0;
  bit         ok;
  ufc_top #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) dut_u (.clk_i, .rst_b_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .tx_in_valid_i(tx_v), .tx_in_ready_o(tx_r), .tx_in_data_i(tx_d), .tx_out_valid_o(tx_ov),
    .tx_out_ready_i(tx_pop), .tx_out_data_o(tx_q), .rx_in_valid_i(rx_v), .rx_in_ready_o(rx_r),
    .rx_in_data_i(rx_d), .rx_out_valid_o(rx_ov), .rx_out_ready_i(rx_pop), .rx_out_data_o(rx_q),
    .tx_request_flag_o(tx_flag), .rx_request_flag_o(rx_flag), .irq_o(irq));
  ufc_link_model lnk_tx (.clk_i, .drain_i(drain_rx), .pop_o(rx_pop), .push_valid_o(tx_v),
    .push_ready_i(tx_r), .push_data_o(tx_d));
  ufc_link_model lnk_rx (.clk_i, .drain_i(drain_tx), .pop_o(tx_pop), .push_valid_o(rx_v),
    .push_ready_i(rx_r), .push_data_o(rx_d));
  // 20 ns period
  always #10 clk_i = ~clk_i;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick
  // One-cycle write strobe
  task automatic wr(input logic [7:0] v);
    reg_wr_i    = 1'b1;
    reg_wdata_i = v;
    tick(1);
    reg_wr_i    = 1'b0;
  endtask : wr
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // A stalled push ends the run; flags settle one edge after the last byte, the irq two
  task automatic fill(input bit to_tx, input int n);
    if (to_tx) lnk_tx.push(n, ok);
    else lnk_rx.push(n, ok);
    if (!ok) begin
      n_mismatch++;
      close_out();
    end
    tick(3);
  endtask : fill
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    tick(1);
    cmp(reg_rdata_o, FCN_RESET);
    cmp({6'h00, irq, tx_flag}, 8'h01);
    cmp({7'h00, rx_flag}, 8'h00);
    // Every tx threshold against levels 0..4; odd thresholds enable the irq
    for (int th = 0; th < 4; th++) begin
      for (int n = 0; n < 5; n++) begin
        wr(8'h40 | 8'(th << 4) | 8'((th % 2) << 7));
        tick(4);
        cmp(reg_rdata_o, 8'(th << 4) | 8'((th % 2) << 7));
        cmp({7'h00, tx_ov}, 8'h00);
        fill(1, n);
        cmp({6'h00, irq, tx_flag}, {6'h00, th % 2 == 1 && n <= th, n <= th});
      end
    end
    // Every rx threshold with its irq enabled
    for (int th = 0; th < 4; th++) begin
      for (int n = 0; n < 5; n++) begin
        wr(8'h0C | 8'(th));
        tick(4);
        cmp(reg_rdata_o, 8'h08 | 8'(th));
        cmp({7'h00, rx_ov}, 8'h00);
        fill(0, n);
        cmp({6'h00, irq, rx_flag}, {6'h00, n > th, n > th});
      end
    end
    // Fill both to refusal with the far side stalled, then drain
    wr(8'h44);
    tick(4);
    fill(1, FIFO_DEPTH);
    fill(0, FIFO_DEPTH);
    cmp({6'h00, tx_r, rx_r}, 8'h00);
    cmp({5'h00, irq, tx_flag, rx_flag}, 8'h01);
    drain_tx = 1'b1;
    drain_rx = 1'b1;
    // Bytes leave in push order, one per edge
    for (int k = 0; k < FIFO_DEPTH; k++) begin
      cmp(tx_q, 8'(k));
      cmp(rx_q, 8'(k));
      tick(1);
    end
    tick(3);
    cmp({6'h00, tx_ov, rx_ov}, 8'h00);
    cmp({5'h00, irq, tx_flag, rx_flag}, 8'h02);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
